// ---- bench/dsm_drive_model.sv ----
// Behavioural power stage: run command, ramp-down and start pulse
`timescale 1ns/1ps
`default_nettype none
module dsm_drive_model (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Commands
  input wire logic run_cmd_in,
  input wire logic stop_request_in,
  input wire logic freq_hold_in,
  // Drive state
  output var logic running_out,
  output var logic decel_out,
  output var logic start_out
);
  logic [7:0] ramp_reg;
  always_ff @(posedge ref_clk_in) begin
    start_out <= 1'b0;
    if (rst_in) begin
      running_out <= 1'b0;
      decel_out <= 1'b0;
      ramp_reg <= 8'h00;
    end else if (run_cmd_in && !running_out) begin
      running_out <= 1'b1;
      start_out <= 1'b1;
    end else if (running_out && !decel_out && (!run_cmd_in || (stop_request_in && !start_out))) begin
      // A stop latched from the last run is still visible in the start cycle
      decel_out <= 1'b1;
      ramp_reg <= 8'h10;
    end else if (decel_out && !freq_hold_in) begin
      if (ramp_reg == 8'h00) begin
        running_out <= 1'b0;
        decel_out <= 1'b0;
      end else begin
        ramp_reg <= ramp_reg - 8'h01;
      end
    end
  end
endmodule // dsm_drive_model
`default_nettype wire

// ---- bench/dsm_monitor_properties.sv ----
// Port-level checks of the supervision monitor
`timescale 1ns/1ps
`default_nettype none
module dsm_props (
  // Clock, reset, bus
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Measurements and drive state
  input wire logic [9:0] analog_input_one_in,
  input wire logic [7:0] heatsink_temp_in,
  input wire logic [9:0] bus_voltage_in,
  input wire logic running_in,
  input wire logic decel_in,
  input wire logic start_in,
  // Outputs
  input wire logic analog_one_out_of_range_out,
  input wire logic module_temp_reached_out,
  input wire logic run_time_reached_out,
  input wire logic timing_reached_out,
  input wire logic fan_on_out,
  input wire logic stop_request_out,
  input wire logic freq_hold_out,
  input wire logic [6:0] stall_gain_out
);
  // Frozen cycles stretch every latency, so they are left out
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in || !ce_in);
  sequence s_answer;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  property p_bus_answer;
    $rose(avs_read_in || avs_write_in) |-> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one cycle");
  property p_bus_idle;
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("waitrequest without request");
  property p_fan_need;
    (running_in || heatsink_temp_in > 8'h28) |=> fan_on_out;
  endproperty
  a_fan_need: assert property (p_fan_need) else $error("fan off when needed");
  property p_range_high;
    analog_input_one_in > 10'h3E8 |=> analog_one_out_of_range_out;
  endproperty
  a_range_high: assert property (p_range_high) else $error("range flag missing");
  property p_temp_top;
    heatsink_temp_in == 8'hFF |=> module_temp_reached_out;
  endproperty
  a_temp_top: assert property (p_temp_top) else $error("temperature flag missing");
  property p_hold_cause;
    decel_in && bus_voltage_in > 10'h31B && stall_gain_out != 7'h00 |=> freq_hold_out;
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold missing");
  property p_hold_need;
    freq_hold_out |-> $past(decel_in) && $past(bus_voltage_in) > 10'h27C
      && $past(stall_gain_out) != 7'h00;
  endproperty
  a_hold_need: assert property (p_hold_need) else $error("hold without cause");
  property p_stop_latch;
    stop_request_out && !start_in |=> stop_request_out;
  endproperty
  a_stop_latch: assert property (p_stop_latch) else $error("stop dropped");
  property p_timing_latch;
    timing_reached_out && !start_in |=> timing_reached_out;
  endproperty
  a_timing_latch: assert property (p_timing_latch) else $error("timing dropped");
  property p_runtime_run;
    run_time_reached_out |-> $past(running_in);
  endproperty
  a_runtime_run: assert property (p_runtime_run) else $error("run time while stopped");
endmodule // dsm_props
bind dsm_monitor dsm_props u_props (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the drive supervision monitor
`timescale 1ns/1ps
`default_nettype none
`include "dsm_consts.vh"
module testbench;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, run_cmd = 1'b0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic [11:0] out_current_in = 12'h000;
  logic [9:0] analog_input_one_in = 10'h1F4, analog_input_two_in = 10'h3E8;
  logic [9:0] analog_input_three_in = 10'h000, bus_voltage_in = 10'h200;
  logic [7:0] heatsink_temp_in = 8'h14;
  logic running_in, decel_in, start_in, avs_waitrequest_out, irq_out, fan_on_out;
  logic current_arrival_one_out, current_arrival_two_out, timing_reached_out;
  logic analog_one_out_of_range_out, module_temp_reached_out, run_time_reached_out;
  logic overload_warning_out, overload_fault_out, stop_request_out, freq_hold_out;
  logic [6:0] stall_gain_out;
  logic [15:0] remaining_run_time_monitor_out;
  int mismatches = 0, checks = 0, n, w;
  logic [31:0] rv [16];
  logic [11:0] cur_t [5] = '{12'h1E0, 12'h1DF, 12'h208, 12'h209, 12'h3E8};
  logic [9:0] ai_t [5] = '{10'h135, 10'h136, 10'h2A8, 10'h2A9, 10'h3E9};
  logic [4:0] arr_e = 5'b00101, ai_e = 5'b11001;
  always #50 ref_clk_in = ~ref_clk_in;
  // Short second tick keeps the timed and overload runs brief
  dsm_monitor #(.SEC_CYCLES(32'h0000000A)) u_dut (.*);
  dsm_drive_model u_drv (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .run_cmd_in(run_cmd),
    .stop_request_in(stop_request_out), .freq_hold_in(freq_hold_out),
    .running_out(running_in), .decel_out(decel_in), .start_out(start_in));
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wait_stop;
    for (int i = 0; i < 300 && running_in !== 1'b0; i++) tick(1);
  endtask
  task automatic test_done;
    $display("Mismatches %0d of %0d checks", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(20000);
    mismatches++;
    test_done;
  end
  initial begin
    rv = '{{20'h0, `DSM_R_CAR_SP}, 32'h0, {20'h0, `DSM_R_CAR_SP}, 32'h0, 32'h0, 32'h0,
      {6'h0, `DSM_R_AI_HI, 6'h0, `DSM_R_AI_LO}, {24'h0, `DSM_R_TEMP_THR}, 32'h0,
      {6'h0, `DSM_R_OL_GAIN, 1'b0, `DSM_R_OL_COEF, 7'h0, 1'b1},
      {9'h0, `DSM_R_OV_GAIN, 6'h0, `DSM_R_OV_THR}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    tick(5);
    rst_in <= 1'b0;
    bus(1'b1, 4'hF, 32'hFFFFFFFF);
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      chk("reg_reset", q, rv[i]);
    end
    chk("stall_gain", 32'(stall_gain_out), 32'(`DSM_R_OV_GAIN));
    bus(1'b1, `DSM_A_CAR_SP1, 32'h000001F4);
    bus(1'b1, `DSM_A_CAR_W1, 32'h00000014);
    for (int i = 0; i < 5; i++) begin
      out_current_in <= cur_t[i];
      analog_input_one_in <= ai_t[i];
      tick(2);
      chk("arrival_one", 32'(current_arrival_one_out), 32'(arr_e[i]));
      chk("ai_range", 32'(analog_one_out_of_range_out), 32'(ai_e[i]));
    end
    out_current_in <= `DSM_R_CAR_SP;
    analog_input_one_in <= 10'h1F4;
    tick(2);
    chk("arrival_two", 32'(current_arrival_two_out), 32'h1);
    heatsink_temp_in <= 8'h28;
    tick(2);
    chk("fan_cool", 32'(fan_on_out), 32'h0);
    ce_in <= 1'b0;
    heatsink_temp_in <= 8'h29;
    tick(3);
    chk("ce_freeze", 32'(fan_on_out), 32'h0);
    ce_in <= 1'b1;
    heatsink_temp_in <= 8'h29;
    tick(2);
    chk("fan_warm", 32'(fan_on_out), 32'h1);
    bus(1'b1, `DSM_A_TEMP, {23'h0, 1'b1, `DSM_R_TEMP_THR});
    heatsink_temp_in <= 8'h14;
    tick(2);
    chk("fan_always", 32'(fan_on_out), 32'h1);
    bus(1'b1, `DSM_A_TEMP, rv[7]);
    tick(2);
    chk("fan_mode_zero", 32'(fan_on_out), 32'h0);
    bus(1'b1, `DSM_A_IRQ_MASK, 32'h00000010);
    heatsink_temp_in <= 8'h4A;
    tick(2);
    chk("temp_below", 32'(module_temp_reached_out), 32'h0);
    bus(1'b1, `DSM_A_IRQ_STAT, 32'h000001FF);
    heatsink_temp_in <= 8'h4B;
    tick(2);
    chk("temp_reached", 32'(module_temp_reached_out), 32'h1);
    chk("irq_raised", 32'(irq_out), 32'h1);
    bus(1'b1, `DSM_A_IRQ_STAT, 32'h00000010);
    tick(1);
    chk("irq_cleared", 32'(irq_out), 32'h0);
    bus(1'b1, `DSM_A_IRQ_MASK, 32'h0);
    heatsink_temp_in <= 8'h4A;
    tick(2);
    heatsink_temp_in <= 8'hFF;
    tick(2);
    chk("irq_masked", 32'(irq_out), 32'h0);
    bus(1'b0, `DSM_A_IRQ_STAT, 32'h0);
    chk("irq_status", q & 32'h00000010, 32'h00000010);
    heatsink_temp_in <= 8'h14;
    // No load while the gain sits at its floor, so the accumulator stays empty
    out_current_in <= 12'h000;
    bus(1'b1, `DSM_A_OL, {6'h0, 10'h005, 1'b0, 7'h28, 7'h0, 1'b1});
    bus(1'b0, `DSM_A_OL, 32'h0);
    chk("ol_clamp", q, {6'h0, `DSM_OL_GAIN_MIN, 1'b0, `DSM_OL_COEF_MIN, 7'h0, 1'b1});
    bus(1'b1, `DSM_A_OL, rv[9]);
    // 220 % at unit gain: warning near 49 s, trip at 60 s of 10 cycles
    out_current_in <= 12'h898;
    n = 0;
    w = 0;
    while (overload_fault_out !== 1'b1 && n < 900) begin
      tick(1);
      n++;
      if (overload_warning_out === 1'b1 && w == 0) w = n;
    end
    chk("ol_warn_time", 32'(w >= 475 && w <= 505), 32'h1);
    chk("ol_trip_time", 32'(n >= 585 && n <= 615), 32'h1);
    bus(1'b1, `DSM_A_OL, rv[9] & 32'hFFFFFFFE);
    tick(2);
    chk("ol_disabled", 32'(overload_fault_out), 32'h0);
    out_current_in <= 12'h000;
    bus(1'b1, `DSM_A_OL, rv[9]);
    bus(1'b1, `DSM_A_TDUR, 32'h00000002);
    bus(1'b1, `DSM_A_RTTHR, 32'h00000001);
    bus(1'b1, `DSM_A_TRUN, 32'h00000001);
    run_cmd <= 1'b1;
    tick(3);
    chk("timed_early", 32'(stop_request_out), 32'h0);
    chk("remaining_full", 32'(remaining_run_time_monitor_out), 32'h2);
    n = 0;
    while (stop_request_out !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk("timed_span", 32'(n >= 55 && n <= 125), 32'h1);
    chk("timed_flag", 32'(timing_reached_out), 32'h1);
    chk("remaining", 32'(remaining_run_time_monitor_out), 32'h0);
    chk("run_time_flag", 32'(run_time_reached_out), 32'h1);
    run_cmd <= 1'b0;
    wait_stop;
    tick(2);
    chk("run_time_idle", 32'(run_time_reached_out), 32'h0);
    // Third analog input sits at zero, so the scaled duration is zero
    bus(1'b1, `DSM_A_TRUN, 32'h00000007);
    run_cmd <= 1'b1;
    tick(6);
    chk("timed_source", 32'(stop_request_out), 32'h1);
    run_cmd <= 1'b0;
    wait_stop;
    bus(1'b1, `DSM_A_TRUN, 32'h0);
    run_cmd <= 1'b1;
    tick(4);
    bus_voltage_in <= 10'h320;
    tick(3);
    chk("no_hold_run", 32'(freq_hold_out), 32'h0);
    run_cmd <= 1'b0;
    tick(4);
    chk("freq_hold", 32'(freq_hold_out), 32'h1);
    bus_voltage_in <= 10'h2BC;
    tick(2);
    chk("hold_release", 32'(freq_hold_out), 32'h0);
    wait_stop;
    test_done;
  end
endmodule // testbench
`default_nettype wire

// ---- hdl/dsm_consts.vh ----
// Register map, reset values, limits and timing constants of the drive supervision monitor
`ifndef DSM_CONSTS_VH
`define DSM_CONSTS_VH
// Register word addresses
`define DSM_A_CAR_SP1 4'h0
`define DSM_A_CAR_W1 4'h1
`define DSM_A_CAR_SP2 4'h2
`define DSM_A_CAR_W2 4'h3
`define DSM_A_TRUN 4'h4
`define DSM_A_TDUR 4'h5
`define DSM_A_AILIM 4'h6
`define DSM_A_TEMP 4'h7
`define DSM_A_RTTHR 4'h8
`define DSM_A_OL 4'h9
`define DSM_A_OV 4'hA
`define DSM_A_STATUS 4'hB
`define DSM_A_REMAIN 4'hC
`define DSM_A_IRQ_STAT 4'hD
`define DSM_A_IRQ_MASK 4'hE
// Field positions
`define DSM_F_TRUN_EN 0
`define DSM_F_TRUN_SRC 2:1
`define DSM_F_LO 9:0
`define DSM_F_HI 25:16
`define DSM_F_TEMP_THR 7:0
`define DSM_F_FAN_MODE 8
`define DSM_F_OL_SEL 0
`define DSM_F_OL_COEF 14:8
`define DSM_F_OL_GAIN 25:16
`define DSM_F_OV_THR 9:0
`define DSM_F_OV_GAIN 22:16
`define DSM_NEV 9
// Reset values (current 0.1 %, volts 0.01 V, time 0.1 min, gain 0.01)
`define DSM_R_CAR_SP 12'h3E8
`define DSM_R_CAR_W 12'h000
`define DSM_R_TDUR 16'h0000
`define DSM_R_AI_LO 10'h136
`define DSM_R_AI_HI 10'h2A8
`define DSM_R_TEMP_THR 8'h4B
`define DSM_R_RTTHR 16'h0000
`define DSM_R_OL_GAIN 10'h064
`define DSM_R_OL_COEF 7'h50
`define DSM_R_OV_THR 10'h2F8
`define DSM_R_OV_GAIN 7'h1E
// Setting limits
`define DSM_MAX_CUR 12'hBB8
`define DSM_AI_FULL 10'h3E8
`define DSM_OL_GAIN_MIN 10'h014
`define DSM_OL_GAIN_MAX 10'h3E8
`define DSM_OL_COEF_MIN 7'h32
`define DSM_OL_COEF_MAX 7'h64
`define DSM_OV_THR_MIN 10'h27C
`define DSM_OV_THR_MAX 10'h31B
`define DSM_OV_GAIN_MAX 7'h64
`define DSM_FAN_TEMP 8'h28
// Inverse-time curve: 220 % for 1 min, 150 % for 60 min
`define DSM_OL_HI_CUR 28'h0000898
`define DSM_OL_LO_CUR 28'h00005DC
`define DSM_OL_HI_MIN 28'h0000001
`define DSM_OL_LO_MIN 28'h000003C
`define DSM_PCT_SCALE 28'h0000064
// Timing
`define DSM_CLK_HZ 32'h00989680
`define DSM_TICK_S 32'h00000001
`define DSM_SEC_PER_MIN 32'h0000003C
`define DSM_SEC_PER_TENTH 3'h6
`endif

// ---- hdl/dsm_monitor.v ----
// Drive supervision monitor: level flags, fan, timed run, overload and overvoltage stall
`timescale 1ns/1ps
`default_nettype none
`include "dsm_consts.vh"
module dsm_monitor #(
  parameter [31:0] SEC_CYCLES = `DSM_CLK_HZ * `DSM_TICK_S
) (
  // Clock, reset, enable
  input wire ref_clk_in,
  input wire rst_in,
  input wire ce_in,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Measurements and drive state
  input wire [11:0] out_current_in,
  input wire [9:0] analog_input_one_in,
  input wire [9:0] analog_input_two_in,
  input wire [9:0] analog_input_three_in,
  input wire [7:0] heatsink_temp_in,
  input wire [9:0] bus_voltage_in,
  input wire running_in,
  input wire decel_in,
  input wire start_in,
  // Flags toward the digital outputs
  output wire current_arrival_one_out,
  output wire current_arrival_two_out,
  output wire timing_reached_out,
  output wire analog_one_out_of_range_out,
  output wire module_temp_reached_out,
  output wire run_time_reached_out,
  output wire overload_warning_out,
  output wire overload_fault_out,
  // Drive control
  output wire fan_on_out,
  output wire stop_request_out,
  output wire freq_hold_out,
  output wire [6:0] stall_gain_out,
  output wire [15:0] remaining_run_time_monitor_out,
  output wire irq_out
);

  function [31:0] clamp;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // Settings
  reg [11:0] car_sp_reg [0:1];
  reg [11:0] car_w_reg [0:1];
  reg timed_run_enable_reg;
  reg [1:0] timed_run_source_select_reg;
  reg [15:0] timed_run_duration_reg;
  reg [9:0] analog_one_lower_limit_reg;
  reg [9:0] analog_one_upper_limit_reg;
  reg [7:0] module_temp_threshold_reg;
  reg fan_control_mode_reg;
  reg [15:0] current_run_time_threshold_reg;
  reg overload_protect_select_reg;
  reg [9:0] overload_protect_gain_reg;
  reg [6:0] overload_warning_coefficient_reg;
  reg [9:0] overvoltage_stall_threshold_reg;
  reg [6:0] overvoltage_stall_gain_reg;
  reg [`DSM_NEV-1:0] irq_stat_reg;
  reg [`DSM_NEV-1:0] irq_mask_reg;
  // State
  reg [31:0] sec_cnt_reg;
  reg [2:0] tenth_cnt_reg;
  reg [15:0] run_timer_reg;
  reg [31:0] ol_acc_reg;
  reg [`DSM_NEV-1:0] flag_reg;
  reg fan_reg;
  reg stop_reg;
  reg [15:0] remain_reg;
  reg done_reg;
  reg [31:0] rdata_reg;

  wire sec_tick = (sec_cnt_reg == SEC_CYCLES - 32'h1);
  wire tenth_tick = sec_tick && (tenth_cnt_reg == `DSM_SEC_PER_TENTH - 3'h1);
  wire [3:0] a = avs_address_in;
  wire req = avs_read_in | avs_write_in;
  wire wr = ce_in & avs_write_in & done_reg;

  // Current arrival bands
  wire [1:0] car_in;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_car
      wire [12:0] lo = (car_sp_reg[gi] > car_w_reg[gi]) ?
        {1'b0, car_sp_reg[gi] - car_w_reg[gi]} : 13'h0000;
      wire [12:0] hi = {1'b0, car_sp_reg[gi]} + {1'b0, car_w_reg[gi]};
      // Both band edges count as inside
      assign car_in[gi] = ({1'b0, out_current_in} >= lo) &&
        ({1'b0, out_current_in} <= hi);
    end
  endgenerate

  // Timed run duration source; full-scale input gives the stored time
  reg [9:0] ai_sel;
  always @* begin
    case (timed_run_source_select_reg)
      2'h1: ai_sel = analog_input_one_in;
      2'h2: ai_sel = analog_input_two_in;
      2'h3: ai_sel = analog_input_three_in;
      default: ai_sel = `DSM_AI_FULL;
    endcase
  end
  wire [9:0] ai_cl = (ai_sel > `DSM_AI_FULL) ? `DSM_AI_FULL : ai_sel;
  wire [25:0] dur_prod = ai_cl * timed_run_duration_reg;
  wire [25:0] dur_quot = dur_prod / {16'h0000, `DSM_AI_FULL};
  wire [15:0] dur_eff = (timed_run_source_select_reg == 2'h0) ?
    timed_run_duration_reg : dur_quot[15:0];
  // The start cycle still sees the last run's timer, so it never counts as a hit
  wire timed_hit = timed_run_enable_reg && running_in && !start_in &&
    (run_timer_reg >= dur_eff);

  // Inverse-time overload: rate is zero-balanced so at unit gain 220 % trips 60x faster than 150 %
  wire [27:0] ol_slope = (`DSM_OL_LO_MIN - `DSM_OL_HI_MIN) * `DSM_PCT_SCALE;
  wire [27:0] ol_offs = (`DSM_OL_LO_MIN * `DSM_OL_LO_CUR -
    `DSM_OL_HI_MIN * `DSM_OL_HI_CUR) * `DSM_PCT_SCALE;
  wire [27:0] ol_pos = ol_slope * {16'h0000, out_current_in};
  wire [27:0] ol_neg = (ol_offs / `DSM_PCT_SCALE) *
    {18'h00000, overload_protect_gain_reg};
  // Rate at 220 % times gain, for one minute of seconds
  wire [27:0] ol_rate_hi = (ol_slope * `DSM_OL_HI_CUR / `DSM_PCT_SCALE) -
    (ol_offs / `DSM_PCT_SCALE);
  wire [31:0] ol_limit = {4'h0, ol_rate_hi} * `DSM_SEC_PER_MIN *
    {22'h000000, overload_protect_gain_reg};
  wire [27:0] ol_up = ol_pos - ol_neg;
  wire [27:0] ol_dn = ol_neg - ol_pos;
  wire [32:0] ol_sum = {1'b0, ol_acc_reg} + {5'h00, ol_up};
  reg [31:0] ol_acc_next;
  always @* begin
    ol_acc_next = ol_acc_reg;
    if (!overload_protect_select_reg) begin
      ol_acc_next = 32'h00000000;
    end else if (sec_tick) begin
      if (ol_pos >= ol_neg) begin
        ol_acc_next = (ol_sum > {1'b0, ol_limit}) ? ol_limit : ol_sum[31:0];
      end else begin
        ol_acc_next = (ol_acc_reg > {4'h0, ol_dn}) ?
          ol_acc_reg - {4'h0, ol_dn} : 32'h00000000;
      end
    end
  end
  wire [39:0] ol_warn_lhs = {8'h00, ol_acc_reg} * 40'h0000000064;
  wire [39:0] ol_warn_rhs = {8'h00, ol_limit} *
    {33'h000000000, overload_warning_coefficient_reg};
  wire ol_trip = overload_protect_select_reg && (ol_acc_reg >= ol_limit) &&
    (ol_limit != 32'h00000000);

  // Flags recomputed every cycle; timed flag holds until restart, overload trip until restart or protection off
  reg [`DSM_NEV-1:0] flag_next;
  always @* begin
    flag_next[1:0] = car_in;
    flag_next[2] = (flag_reg[2] && !start_in) || timed_hit;
    flag_next[3] = (analog_input_one_in > analog_one_upper_limit_reg) ||
      (analog_input_one_in < analog_one_lower_limit_reg);
    flag_next[4] = heatsink_temp_in >= module_temp_threshold_reg;
    flag_next[5] = running_in && !start_in &&
      (run_timer_reg >= current_run_time_threshold_reg);
    flag_next[6] = overload_protect_select_reg &&
      (ol_warn_lhs > ol_warn_rhs);
    flag_next[7] = overload_protect_select_reg &&
      ((flag_reg[7] && !start_in) || ol_trip);
    // Hold frequency only while decelerating over the threshold
    flag_next[8] = decel_in && (overvoltage_stall_gain_reg != 7'h00) &&
      (bus_voltage_in > overvoltage_stall_threshold_reg);
  end

  // Fan control
  reg fan_next;
  always @* begin
    case (fan_control_mode_reg)
      1'b1: fan_next = 1'b1;
      default: fan_next = running_in ||
        (heatsink_temp_in > `DSM_FAN_TEMP);
    endcase
  end

  wire [`DSM_NEV-1:0] ev_rise = flag_next & ~flag_reg;

  // Register readback, also the base for byte-lane merges
  function [31:0] rd_mux;
    input [3:0] ad;
    begin
      case (ad)
        `DSM_A_CAR_SP1: rd_mux = {20'h00000, car_sp_reg[0]};
        `DSM_A_CAR_W1: rd_mux = {20'h00000, car_w_reg[0]};
        `DSM_A_CAR_SP2: rd_mux = {20'h00000, car_sp_reg[1]};
        `DSM_A_CAR_W2: rd_mux = {20'h00000, car_w_reg[1]};
        `DSM_A_TRUN: rd_mux = {29'h00000000, timed_run_source_select_reg,
          timed_run_enable_reg};
        `DSM_A_TDUR: rd_mux = {16'h0000, timed_run_duration_reg};
        `DSM_A_AILIM: rd_mux = {6'h00, analog_one_upper_limit_reg, 6'h00,
          analog_one_lower_limit_reg};
        `DSM_A_TEMP: rd_mux = {23'h000000, fan_control_mode_reg,
          module_temp_threshold_reg};
        `DSM_A_RTTHR: rd_mux = {16'h0000, current_run_time_threshold_reg};
        `DSM_A_OL: rd_mux = {6'h00, overload_protect_gain_reg, 1'b0,
          overload_warning_coefficient_reg, 7'h00, overload_protect_select_reg};
        `DSM_A_OV: rd_mux = {9'h000, overvoltage_stall_gain_reg, 6'h00,
          overvoltage_stall_threshold_reg};
        `DSM_A_STATUS: rd_mux = {21'h000000, running_in, fan_reg, flag_reg};
        `DSM_A_REMAIN: rd_mux = {16'h0000, remain_reg};
        `DSM_A_IRQ_STAT: rd_mux = {23'h000000, irq_stat_reg};
        `DSM_A_IRQ_MASK: rd_mux = {23'h000000, irq_mask_reg};
        default: rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire [31:0] wd = (rd_mux(a) & ~be_mask) | (avs_writedata_in & be_mask);
  // Clamps work on full words; each register keeps only its own width
  wire [31:0] ai_hi_c = clamp({22'h0, wd[`DSM_F_HI]}, 32'h0,
    {22'h0, `DSM_AI_FULL});
  wire [9:0] ai_hi_w = ai_hi_c[9:0];
  wire [31:0] ai_lo_c = clamp({22'h0, wd[`DSM_F_LO]}, 32'h0, {22'h0, ai_hi_w});
  wire [9:0] ai_lo_w = ai_lo_c[9:0];
  wire [31:0] cur_c = clamp({20'h0, wd[11:0]}, 32'h0, {20'h0, `DSM_MAX_CUR});
  wire [31:0] ol_gain_c = clamp({22'h0, wd[`DSM_F_OL_GAIN]},
    {22'h0, `DSM_OL_GAIN_MIN}, {22'h0, `DSM_OL_GAIN_MAX});
  wire [31:0] ol_coef_c = clamp({25'h0, wd[`DSM_F_OL_COEF]},
    {25'h0, `DSM_OL_COEF_MIN}, {25'h0, `DSM_OL_COEF_MAX});
  wire [31:0] ov_thr_c = clamp({22'h0, wd[`DSM_F_OV_THR]},
    {22'h0, `DSM_OV_THR_MIN}, {22'h0, `DSM_OV_THR_MAX});
  wire [31:0] ov_gain_c = clamp({25'h0, wd[`DSM_F_OV_GAIN]}, 32'h0,
    {25'h0, `DSM_OV_GAIN_MAX});

  // Register writes and bus answer
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      car_sp_reg[0] <= `DSM_R_CAR_SP;
      car_sp_reg[1] <= `DSM_R_CAR_SP;
      car_w_reg[0] <= `DSM_R_CAR_W;
      car_w_reg[1] <= `DSM_R_CAR_W;
      timed_run_enable_reg <= 1'b0;
      timed_run_source_select_reg <= 2'h0;
      timed_run_duration_reg <= `DSM_R_TDUR;
      analog_one_lower_limit_reg <= `DSM_R_AI_LO;
      analog_one_upper_limit_reg <= `DSM_R_AI_HI;
      module_temp_threshold_reg <= `DSM_R_TEMP_THR;
      fan_control_mode_reg <= 1'b0;
      current_run_time_threshold_reg <= `DSM_R_RTTHR;
      overload_protect_select_reg <= 1'b1;
      overload_protect_gain_reg <= `DSM_R_OL_GAIN;
      overload_warning_coefficient_reg <= `DSM_R_OL_COEF;
      overvoltage_stall_threshold_reg <= `DSM_R_OV_THR;
      overvoltage_stall_gain_reg <= `DSM_R_OV_GAIN;
      irq_stat_reg <= {`DSM_NEV{1'b0}};
      irq_mask_reg <= {`DSM_NEV{1'b0}};
      done_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else if (ce_in) begin
      done_reg <= req & ~done_reg;
      if (req & ~done_reg) begin
        rdata_reg <= avs_read_in ? rd_mux(a) : 32'h00000000;
      end
      // New events win over a write-one clear in the same cycle
      irq_stat_reg <= (irq_stat_reg &
        ~((wr && a == `DSM_A_IRQ_STAT) ? wd[`DSM_NEV-1:0] : {`DSM_NEV{1'b0}}))
        | ev_rise;
      if (wr) begin
        case (a)
          `DSM_A_CAR_SP1: car_sp_reg[0] <= cur_c[11:0];
          `DSM_A_CAR_W1: car_w_reg[0] <= cur_c[11:0];
          `DSM_A_CAR_SP2: car_sp_reg[1] <= cur_c[11:0];
          `DSM_A_CAR_W2: car_w_reg[1] <= cur_c[11:0];
          `DSM_A_TRUN: begin
            timed_run_enable_reg <= wd[`DSM_F_TRUN_EN];
            timed_run_source_select_reg <= wd[`DSM_F_TRUN_SRC];
          end
          `DSM_A_TDUR: timed_run_duration_reg <= wd[15:0];
          `DSM_A_AILIM: begin
            // Lower never above upper, upper never above full scale
            analog_one_upper_limit_reg <= ai_hi_w;
            analog_one_lower_limit_reg <= ai_lo_w;
          end
          `DSM_A_TEMP: begin
            module_temp_threshold_reg <= wd[`DSM_F_TEMP_THR];
            fan_control_mode_reg <= wd[`DSM_F_FAN_MODE];
          end
          `DSM_A_RTTHR: current_run_time_threshold_reg <= wd[15:0];
          `DSM_A_OL: begin
            overload_protect_select_reg <= wd[`DSM_F_OL_SEL];
            overload_protect_gain_reg <= ol_gain_c[9:0];
            overload_warning_coefficient_reg <= ol_coef_c[6:0];
          end
          `DSM_A_OV: begin
            overvoltage_stall_threshold_reg <= ov_thr_c[9:0];
            overvoltage_stall_gain_reg <= ov_gain_c[6:0];
          end
          `DSM_A_IRQ_MASK: irq_mask_reg <= wd[`DSM_NEV-1:0];
          default: ;
        endcase
      end
    end
  end

  // Supervision state
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      sec_cnt_reg <= 32'h00000000;
      tenth_cnt_reg <= 3'h0;
      run_timer_reg <= 16'h0000;
      ol_acc_reg <= 32'h00000000;
      flag_reg <= {`DSM_NEV{1'b0}};
      fan_reg <= 1'b0;
      stop_reg <= 1'b0;
      remain_reg <= 16'h0000;
    end else if (ce_in) begin
      sec_cnt_reg <= sec_tick ? 32'h00000000 : sec_cnt_reg + 32'h1;
      if (start_in) begin
        // Restart the tenth phase too; the second counter runs on, so a run's first tenth can be up to one second short
        tenth_cnt_reg <= 3'h0;
        run_timer_reg <= 16'h0000;
      end else if (running_in && sec_tick) begin
        tenth_cnt_reg <= tenth_tick ? 3'h0 : tenth_cnt_reg + 3'h1;
        if (tenth_tick && run_timer_reg != 16'hFFFF) begin
          run_timer_reg <= run_timer_reg + 16'h1;
        end
      end
      ol_acc_reg <= ol_acc_next;
      flag_reg <= flag_next;
      fan_reg <= fan_next;
      // Stop request holds until the next start
      stop_reg <= (stop_reg && !start_in) || timed_hit || ol_trip;
      remain_reg <= (!timed_run_enable_reg || run_timer_reg >= dur_eff) ?
        16'h0000 : dur_eff - run_timer_reg;
    end
  end

  assign avs_waitrequest_out = req & ~done_reg;
  assign avs_readdata_out = rdata_reg;
  assign current_arrival_one_out = flag_reg[0];
  assign current_arrival_two_out = flag_reg[1];
  assign timing_reached_out = flag_reg[2];
  assign analog_one_out_of_range_out = flag_reg[3];
  assign module_temp_reached_out = flag_reg[4];
  assign run_time_reached_out = flag_reg[5];
  assign overload_warning_out = flag_reg[6];
  assign overload_fault_out = flag_reg[7];
  assign freq_hold_out = flag_reg[8];
  assign fan_on_out = fan_reg;
  assign stop_request_out = stop_reg;
  assign stall_gain_out = overvoltage_stall_gain_reg;
  assign remaining_run_time_monitor_out = remain_reg;
  // Level interrupt, no extra flop so a clear drops it at once
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

endmodule // dsm_monitor
`default_nettype wire
